/* fio_contact_src.sv */
// behavioural dry contacts and open-collector pulse sources
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// contact source model
// ************************************************************
module fio_contact_src #(
    parameter int MIN_PHASE = 12
) (
    input wire logic clk,
    output logic [fio_pkg::NUM_UI-1:0] ui_closed,
    output logic [fio_pkg::NUM_CI-1:0] ci_closed
);
    initial begin
        ui_closed = '0;
        ci_closed = '0;
    end
    // drive one contact of either group
    task automatic put(input bit is_ui, input int ch, input logic lvl);
        if (is_ui) ui_closed[ch] <= lvl;
        else ci_closed[ch] <= lvl;
    endtask
    task automatic move(input bit is_ui, input int ch, input logic lvl, input int chatter);
        for (int i = 0; i < chatter; i++) begin
            @(posedge clk);
            put(is_ui, ch, lvl ^ i[0]);
        end
        @(posedge clk);
        put(is_ui, ch, lvl);
        repeat (MIN_PHASE) @(posedge clk);
    endtask
    task automatic pulse(input bit is_ui, input int ch);
        move(is_ui, ch, 1'b1, 0);
        move(is_ui, ch, 1'b0, 0);
    endtask
    // a closure shorter than the filter time, meant to be ignored
    task automatic glitch(input bit is_ui, input int ch, input int len);
        @(posedge clk);
        put(is_ui, ch, 1'b1);
        repeat (len) @(posedge clk);
        put(is_ui, ch, 1'b0);
        repeat (MIN_PHASE) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* fio_debounce.sv */
// contact debounce filter: a level change is accepted once it has held
`timescale 1ns/1ps
`default_nettype none

module fio_debounce #(
    parameter int CYC = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic raw,
    output logic stable_r
);

    localparam int CW = (CYC > 1) ? $clog2(CYC) : 1;

    logic [CW-1:0] cnt_r;
    logic differ;
    logic done;

    // ************************************************************
    // filter
    // ************************************************************
    assign differ = raw ^ stable_r;
    assign done = (cnt_r == CW'(CYC - 1));

    // any return to the old level restarts the wait, so bounce never leaks
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
            stable_r <= 1'b0;
        end else if (!differ) begin
            cnt_r <= '0;
        end else if (done) begin
            cnt_r <= '0;
            stable_r <= raw;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

endmodule

`default_nettype wire

/* fio_field_io.sv */
// onboard field i/o: contact inputs, pulse counters and analog output codes
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - polarity per input, normal reports closed as one
// - counters step on rising conditioned edges only
// - universal counters keep up with 0.4 Hz
// - universal inputs reject 50 ms bounce
// - contact counters keep up with 15 Hz
// - application stop drives every output to safety
// - binary output mode drives 0 V or 10 V codes
// - ten universal inputs, analog, binary or counter
// - four outputs, own safety value and mode
// - four contact inputs, static or fast counter
// - contact inputs tolerate 5 ms bounce
module fio_field_io #(
    parameter int UI_DB_CYC = fio_pkg::UI_DB_CYC,
    parameter int CI_DB_CYC = fio_pkg::CI_DB_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [fio_pkg::NUM_UI-1:0] universal_input_closed,
    input wire logic [fio_pkg::NUM_CI-1:0] contact_input_closed,
    output logic [fio_pkg::NUM_AO-1:0][fio_pkg::AO_W-1:0] analog_output_channel_code,
    output logic [fio_pkg::NUM_UI-1:0] universal_input_state,
    output logic [fio_pkg::NUM_CI-1:0] contact_input_state
);

    localparam int NU = fio_pkg::NUM_UI;
    localparam int NC = fio_pkg::NUM_CI;
    localparam int NA = fio_pkg::NUM_AO;
    localparam int CW = fio_pkg::CNT_W;
    localparam int AW = fio_pkg::AO_W;
    localparam int MW = NU * fio_pkg::UI_MODE_FW;

    // merge write data into an old word lane by lane
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return res;
    endfunction

    // ************************************************************
    // registers
    // ************************************************************
    logic run_r;
    logic [MW-1:0] ui_mode_r;
    logic [NU-1:0] ui_pol_r;
    logic [NC-1:0] ci_mode_r;
    logic [NC-1:0] ci_pol_r;
    logic [NA-1:0] ao_bin_mode_r;
    logic [NA-1:0] ao_bin_state_r;
    logic [NA-1:0][AW-1:0] ao_val_r;
    logic [NA-1:0][AW-1:0] ao_safe_r;
    logic [NU-1:0][CW-1:0] ui_cnt_r;
    logic [NC-1:0][CW-1:0] ci_cnt_r;
    logic [NU-1:0] ui_db;
    logic [NC-1:0] ci_db;
    logic [NU-1:0] ui_db_q_r;
    logic [NC-1:0] ci_db_q_r;
    logic [NA-1:0][AW-1:0] ao_nxt;
    logic [NU-1:0] ui_state_nxt;
    logic [NU-1:0] ui_cnt_en;

    // ************************************************************
    // bus decode
    // ************************************************************
    logic wr_acc;
    logic rd_take;
    logic [3:0] idx;
    logic sel_ao_val;
    logic sel_ao_safe;
    logic sel_ui_cnt;
    logic sel_ci_cnt;
    logic [31:0] rd_mux;
    logic [31:0] wr_word;

    // a request is answered on the cycle after it is seen
    assign wr_acc = avs_write & ~avs_waitrequest;
    assign rd_take = avs_read & avs_waitrequest;
    assign idx = avs_address[5:2];
    assign sel_ao_val = (avs_address[7:4] == fio_pkg::BANK_AO_VAL);
    assign sel_ao_safe = (avs_address[7:4] == fio_pkg::BANK_AO_SAFE);
    assign sel_ui_cnt = (avs_address[7:6] == fio_pkg::BANK_UI_CNT) && (idx < 4'(NU));
    assign sel_ci_cnt = (avs_address[7:6] == fio_pkg::BANK_CI_CNT) && (idx < 4'(NC));

    // read selection; unmapped addresses and reserved bits read zero
    assign rd_mux =
        (avs_address == fio_pkg::OFF_CTRL) ? {31'h0, run_r} :
        (avs_address == fio_pkg::OFF_UI_MODE) ? {12'h000, ui_mode_r} :
        (avs_address == fio_pkg::OFF_UI_POL) ? {22'h0, ui_pol_r} :
        (avs_address == fio_pkg::OFF_CI_MODE) ? {28'h0, ci_mode_r} :
        (avs_address == fio_pkg::OFF_CI_POL) ? {28'h0, ci_pol_r} :
        (avs_address == fio_pkg::OFF_UI_STATE) ? {22'h0, universal_input_state} :
        (avs_address == fio_pkg::OFF_CI_STATE) ? {28'h0, contact_input_state} :
        (avs_address == fio_pkg::OFF_AO_BIN_MODE) ? {28'h0, ao_bin_mode_r} :
        (avs_address == fio_pkg::OFF_AO_BIN_STATE) ? {28'h0, ao_bin_state_r} :
        sel_ao_val ? {24'h0, ao_val_r[idx[1:0]]} :
        sel_ao_safe ? {24'h0, ao_safe_r[idx[1:0]]} :
        sel_ui_cnt ? ui_cnt_r[idx] :
        sel_ci_cnt ? ci_cnt_r[idx[1:0]] :
        32'h00000000;

    // write word: old contents with only the enabled byte lanes replaced
    assign wr_word = merge(rd_mux, avs_writedata, avs_byteenable);

    // one wait cycle then one ready cycle per request
    always_ff @(posedge clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            if (rd_take) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    // per-output safety value and mode
    always_ff @(posedge clk) begin
        if (rst) begin
            run_r <= fio_pkg::RST_RUN;
            ui_mode_r <= fio_pkg::RST_UI_MODE;
            ui_pol_r <= fio_pkg::RST_UI_POL;
            ci_mode_r <= fio_pkg::RST_CI_MODE;
            ci_pol_r <= fio_pkg::RST_CI_POL;
            ao_bin_mode_r <= fio_pkg::RST_AO_BIN;
            ao_bin_state_r <= fio_pkg::RST_AO_BIN;
            ao_val_r <= {NA{fio_pkg::RST_AO_CODE}};
            ao_safe_r <= {NA{fio_pkg::RST_AO_CODE}};
        end else if (wr_acc) begin
            case (avs_address)
                fio_pkg::OFF_CTRL:
                    run_r <= wr_word[fio_pkg::CTRL_RUN_BIT];
                fio_pkg::OFF_UI_MODE:
                    ui_mode_r <= wr_word[MW-1:0];
                fio_pkg::OFF_UI_POL:
                    ui_pol_r <= wr_word[NU-1:0];
                fio_pkg::OFF_CI_MODE:
                    ci_mode_r <= wr_word[NC-1:0];
                fio_pkg::OFF_CI_POL:
                    ci_pol_r <= wr_word[NC-1:0];
                fio_pkg::OFF_AO_BIN_MODE:
                    ao_bin_mode_r <= wr_word[NA-1:0];
                fio_pkg::OFF_AO_BIN_STATE:
                    ao_bin_state_r <= wr_word[NA-1:0];
                default: begin
                    if (sel_ao_val) begin
                        ao_val_r[idx[1:0]] <= wr_word[AW-1:0];
                    end
                    if (sel_ao_safe) begin
                        ao_safe_r[idx[1:0]] <= wr_word[AW-1:0];
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // input conditioning
    // ************************************************************
    // slow filter on universal inputs
    for (genvar g = 0; g < NU; g++) begin : g_ui
        fio_debounce #(
            .CYC(UI_DB_CYC)
        ) u_db (
            .clk(clk),
            .rst(rst),
            .raw(universal_input_closed[g]),
            .stable_r(ui_db[g])
        );
    end

    for (genvar g = 0; g < NC; g++) begin : g_ci
        fio_debounce #(
            .CYC(CI_DB_CYC)
        ) u_db (
            .clk(clk),
            .rst(rst),
            .raw(contact_input_closed[g]),
            .stable_r(ci_db[g])
        );
    end

    // mode decode; the reserved code acts as analog (no digital state)
    always_comb begin
        for (int i = 0; i < NU; i++) begin
            ui_cnt_en[i] = (ui_mode_r[2*i +: 2] == 2'(fio_pkg::FIO_UI_COUNTER));
            ui_state_nxt[i] = 1'b0;
            if (ui_cnt_en[i] || (ui_mode_r[2*i +: 2] == 2'(fio_pkg::FIO_UI_BINARY))) begin
                ui_state_nxt[i] = ui_db[i] ^ ui_pol_r[i];
            end
        end
    end

    // reported states and edge history
    always_ff @(posedge clk) begin
        if (rst) begin
            ui_db_q_r <= '0;
            ci_db_q_r <= '0;
            universal_input_state <= '0;
            contact_input_state <= '0;
        end else begin
            ui_db_q_r <= ui_db;
            ci_db_q_r <= ci_db;
            universal_input_state <= ui_state_nxt;
            contact_input_state <= ci_db ^ ci_pol_r;
        end
    end

    // ************************************************************
    // pulse counters
    // ************************************************************
    logic [NU-1:0] ui_rise;
    logic [NC-1:0] ci_rise;

    // edge where the conditioned level turns to one
    // taken from the filtered level, so changing polarity never counts
    assign ui_rise = (ui_db ^ ui_db_q_r) & (ui_db ^ ui_pol_r) & ui_cnt_en;
    assign ci_rise = (ci_db ^ ci_db_q_r) & (ci_db ^ ci_pol_r) & ci_mode_r;

    // readable count, cleared by writing its word
    // universal counting rate is bounded only by the filter
    // an edge in the clearing cycle is kept as a count of one
    always_ff @(posedge clk) begin
        if (rst) begin
            ui_cnt_r <= '0;
        end else begin
            for (int i = 0; i < NU; i++) begin
                if (wr_acc && sel_ui_cnt && (idx == 4'(i))) begin
                    ui_cnt_r[i] <= CW'(ui_rise[i]);
                end else if (ui_rise[i]) begin
                    ui_cnt_r[i] <= ui_cnt_r[i] + 1'b1;
                end
            end
        end
    end

    // fast counters with the short filter
    always_ff @(posedge clk) begin
        if (rst) begin
            ci_cnt_r <= '0;
        end else begin
            for (int i = 0; i < NC; i++) begin
                if (wr_acc && sel_ci_cnt && (idx == 4'(i))) begin
                    ci_cnt_r[i] <= CW'(ci_rise[i]);
                end else if (ci_rise[i]) begin
                    ci_cnt_r[i] <= ci_cnt_r[i] + 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // analog output codes
    // ************************************************************
    always_comb begin
        for (int i = 0; i < NA; i++) begin
            if (!run_r) begin
                ao_nxt[i] = ao_safe_r[i];
            // binary mode drives only two codes
            end else if (ao_bin_mode_r[i]) begin
                ao_nxt[i] = ao_bin_state_r[i] ? fio_pkg::AO_CODE_10V : fio_pkg::AO_CODE_0V;
            end else begin
                ao_nxt[i] = ao_val_r[i];
            end
        end
    end

    // registered so the converter sees a glitch-free code
    always_ff @(posedge clk) begin
        if (rst) begin
            analog_output_channel_code <= {NA{fio_pkg::RST_AO_CODE}};
        end else begin
            analog_output_channel_code <= ao_nxt;
        end
    end

endmodule

`default_nettype wire

/* fio_field_io_bench.sv */
// self-checking bench for the field i/o block
`timescale 1ns/1ps
`default_nettype none
`define FIO_CHECK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin failures++; \
    $display("[ERR] %s expected %h seen %h", what, exp, got); end end
// ************************************************************
// bench top
// ************************************************************
module fio_field_io_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'hF;
    logic [31:0] rdata;
    logic waitreq;
    logic [fio_pkg::NUM_UI-1:0] ui_closed, ui_state;
    logic [fio_pkg::NUM_CI-1:0] ci_closed, ci_state;
    logic [fio_pkg::NUM_AO-1:0][fio_pkg::AO_W-1:0] codes, exp_codes;
    logic [7:0] offs [14] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20,
        8'h40, 8'h50, 8'h80, 8'hC0, 8'h3C};
    int failures = 0;
    int n_compared = 0;
    fio_field_io #(.UI_DB_CYC(8), .CI_DB_CYC(4)) dut (.clk(clk), .rst(rst),
        .avs_address(address), .avs_read(read), .avs_write(write), .avs_writedata(wdata),
        .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(waitreq),
        .universal_input_closed(ui_closed), .contact_input_closed(ci_closed),
        .analog_output_channel_code(codes), .universal_input_state(ui_state),
        .contact_input_state(ci_state));
    fio_contact_src #(.MIN_PHASE(12)) src (.clk(clk), .ui_closed(ui_closed), .ci_closed(ci_closed));
    initial forever #12.5 clk = ~clk;
    // verdict and end of run
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // one bus cycle: hold until waitrequest is seen low, take data at that edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        wdata <= d;
        write <= wr;
        read <= !wr;
        @(posedge clk);
        while (waitreq !== 1'b0 && n < 40) begin
            @(posedge clk);
            n++;
        end
        if (waitreq !== 1'b0) begin
            failures++;
            test_done();
        end
        q = rdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        `FIO_CHECK(what, exp, q)
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        test_done();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (offs[i]) rd_chk("reset word", offs[i], 32'h0);
        $display("test reset done");
        // contact polarity, bounce rejected
        src.move(0, 0, 1'b1, 3);
        settle(0);
        `FIO_CHECK("ci state closed", 4'h1, ci_state)
        wr(fio_pkg::OFF_CI_POL, 32'h1);
        settle(2);
        `FIO_CHECK("ci state reversed", 4'h0, ci_state)
        src.move(0, 0, 1'b0, 3);
        rd_chk("ci state word", fio_pkg::OFF_CI_STATE, 32'h1);
        src.glitch(0, 1, 3);
        `FIO_CHECK("ci glitch", 4'h1, ci_state)
        $display("test contact polarity done");
        // fast counters, channel 2 reversed so it counts at openings
        wr(fio_pkg::OFF_CI_POL, 32'h4);
        wr(fio_pkg::OFF_CI_MODE, 32'hF);
        for (int i = 0; i < 4; i++) wr(8'hC0 + 8'(4 * i), 32'hFFFF);
        for (int k = 0; k < 3; k++) begin
            src.pulse(0, 1);
            src.pulse(0, 2);
        end
        src.glitch(0, 1, 3);
        rd_chk("ci count 1", 8'hC4, 32'h3);
        rd_chk("ci count 2", 8'hC8, 32'h3);
        rd_chk("ci count 0", 8'hC0, 32'h0);
        src.move(0, 1, 1'b1, 3);
        rd_chk("ci count rise", 8'hC4, 32'h4);
        src.move(0, 1, 1'b0, 3);
        rd_chk("ci count fall", 8'hC4, 32'h4);
        wr(8'hC4, 32'h0);
        rd_chk("ci count clear", 8'hC4, 32'h0);
        $display("test contact counters done");
        // universal inputs: ch0 binary, ch5 analog, ch9 counter
        wr(fio_pkg::OFF_UI_MODE, 32'h0008_0001);
        src.move(1, 5, 1'b1, 0);
        src.move(1, 0, 1'b1, 5);
        `FIO_CHECK("ui state", 10'h001, ui_state)
        src.pulse(1, 9);
        src.pulse(1, 9);
        rd_chk("ui count 9", 8'hA4, 32'h2);
        rd_chk("ui count 0", 8'h80, 32'h0);
        wr(fio_pkg::OFF_UI_POL, 32'h1);
        settle(2);
        `FIO_CHECK("ui reversed", 10'h000, ui_state)
        wr(fio_pkg::OFF_UI_STATE, 32'h3FF);
        rd_chk("ui state ro", fio_pkg::OFF_UI_STATE, 32'h0);
        $display("test universal inputs done");
        // outputs: safety while stopped, values while running, binary codes
        for (int i = 0; i < 4; i++) begin
            wr(8'h40 + 8'(4 * i), 32'(8'h11 * (i + 1)));
            wr(8'h50 + 8'(4 * i), 32'(8'hA0 + i));
        end
        // a write on an unused byte lane leaves the 8-bit value alone
        be <= 4'h2;
        wr(8'h40, 32'h0000_00EE);
        be <= 4'hF;
        rd_chk("ao lane", 8'h40, 32'h11);
        settle(2);
        exp_codes = {8'hA3, 8'hA2, 8'hA1, 8'hA0};
        `FIO_CHECK("codes stopped", exp_codes, codes)
        wr(fio_pkg::OFF_CTRL, 32'h1);
        wr(fio_pkg::OFF_AO_BIN_MODE, 32'hC);
        wr(fio_pkg::OFF_AO_BIN_STATE, 32'h4);
        settle(2);
        exp_codes = {fio_pkg::AO_CODE_0V, fio_pkg::AO_CODE_10V, 8'h22, 8'h11};
        `FIO_CHECK("codes running", exp_codes, codes)
        wr(fio_pkg::OFF_CTRL, 32'h0);
        settle(2);
        exp_codes = {8'hA3, 8'hA2, 8'hA1, 8'hA0};
        `FIO_CHECK("codes stop again", exp_codes, codes)
        $display("test outputs done");
        test_done();
    end
endmodule
`default_nettype wire

/* fio_field_io_props.sv */
// checker for the field i/o bus handshake, debounce and output codes
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// field i/o checker
// ************************************************************
module fio_field_io_props #(
    parameter int UI_DB_CYC = 8,
    parameter int CI_DB_CYC = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [fio_pkg::NUM_UI-1:0] universal_input_closed,
    input wire logic [fio_pkg::NUM_CI-1:0] contact_input_closed,
    input wire logic [fio_pkg::NUM_AO-1:0][fio_pkg::AO_W-1:0] analog_output_channel_code,
    input wire logic [fio_pkg::NUM_UI-1:0] universal_input_state,
    input wire logic [fio_pkg::NUM_CI-1:0] contact_input_state
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [7:0] ci_quiet_r;
    logic [7:0] ui_quiet_r;
    logic [2:0] wr_age_r;
    // quiet time of channel 0 and age of last accepted write; saturate so they never wrap
    always_ff @(posedge clk) begin
        ci_quiet_r <= (rst || $changed(contact_input_closed[0])) ? 8'h00 :
            ci_quiet_r + {7'h00, ci_quiet_r != 8'hFF};
        ui_quiet_r <= (rst || $changed(universal_input_closed[0])) ? 8'h00 :
            ui_quiet_r + {7'h00, ui_quiet_r != 8'hFF};
        wr_age_r <= rst ? 3'h7 : (avs_write && !avs_waitrequest) ? 3'h0 :
            wr_age_r + {2'h0, wr_age_r != 3'h7};
    end
    property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait low too long");
    property p_wait_answer; (avs_read || avs_write) && avs_waitrequest &&
        !$past(avs_read || avs_write) |=> !avs_waitrequest; endproperty
    a_wait_answer: assert property (p_wait_answer) else $error("no answer");
    property p_wait_cause; $fell(avs_waitrequest) |-> $past(avs_read || avs_write); endproperty
    a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
    property p_rd_hold; $changed(avs_readdata) |-> $past(avs_read); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("readdata moved");
    property p_rst_clear; $fell(rst) |-> analog_output_channel_code == '0 &&
        universal_input_state == '0 && contact_input_state == '0 && avs_waitrequest; endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("reset values wrong");
    property p_ci_bounce; $changed(contact_input_state[0]) && wr_age_r > 3'h4 |->
        ci_quiet_r >= CI_DB_CYC - 2; endproperty
    a_ci_bounce: assert property (p_ci_bounce) else $error("contact bounce passed");
    property p_ui_bounce; $changed(universal_input_state[0]) && wr_age_r > 3'h4 |->
        ui_quiet_r >= UI_DB_CYC - 2; endproperty
    a_ui_bounce: assert property (p_ui_bounce) else $error("universal bounce passed");
    property p_code_by_write; $changed(analog_output_channel_code) |-> wr_age_r < 3'h4; endproperty
    a_code_by_write: assert property (p_code_by_write) else $error("code moved alone");
    c_ci_rise: cover property ($rose(contact_input_state[1]));
    c_code_move: cover property ($changed(analog_output_channel_code));
    c_read_answer: cover property (avs_read && !avs_waitrequest);
endmodule
bind fio_field_io fio_field_io_props #(.UI_DB_CYC(UI_DB_CYC), .CI_DB_CYC(CI_DB_CYC)) u_props (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .universal_input_closed(universal_input_closed), .contact_input_closed(contact_input_closed),
    .analog_output_channel_code(analog_output_channel_code),
    .universal_input_state(universal_input_state), .contact_input_state(contact_input_state));
`default_nettype wire

/* fio_pkg.sv */
// constants, register map and modes of the onboard field i/o block
package fio_pkg;

    // ************************************************************
    // channel counts and widths
    // ************************************************************
    localparam int NUM_UI = 10;
    localparam int NUM_CI = 4;
    localparam int NUM_AO = 4;
    localparam int CNT_W = 32;
    localparam int AO_W = 8;

    // ************************************************************
    // timing
    // ************************************************************
    localparam longint CLK_HZ = 40_000_000;
    localparam longint UI_BOUNCE_MS = 50;
    localparam longint CI_BOUNCE_MS = 5;
    // least times: round up to whole cycles
    localparam int UI_DB_CYC = int'((UI_BOUNCE_MS * CLK_HZ + 999) / 1000);
    localparam int CI_DB_CYC = int'((CI_BOUNCE_MS * CLK_HZ + 999) / 1000);

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_UI_MODE = 8'h04;
    localparam logic [7:0] OFF_UI_POL = 8'h08;
    localparam logic [7:0] OFF_CI_MODE = 8'h0C;
    localparam logic [7:0] OFF_CI_POL = 8'h10;
    localparam logic [7:0] OFF_UI_STATE = 8'h14;
    localparam logic [7:0] OFF_CI_STATE = 8'h18;
    localparam logic [7:0] OFF_AO_BIN_MODE = 8'h1C;
    localparam logic [7:0] OFF_AO_BIN_STATE = 8'h20;
    // banks: upper address bits select, word index in [5:2] or [3:2]
    localparam logic [3:0] BANK_AO_VAL = 4'h4;
    localparam logic [3:0] BANK_AO_SAFE = 4'h5;
    localparam logic [1:0] BANK_UI_CNT = 2'h2;
    localparam logic [1:0] BANK_CI_CNT = 2'h3;

    // ************************************************************
    // fields and reset values
    // ************************************************************
    localparam int CTRL_RUN_BIT = 0;
    localparam int UI_MODE_FW = 2;
    localparam logic [AO_W-1:0] AO_CODE_0V = 8'h00;
    localparam logic [AO_W-1:0] AO_CODE_10V = 8'hFF;
    localparam logic RST_RUN = 1'h0;
    localparam logic [NUM_UI*UI_MODE_FW-1:0] RST_UI_MODE = 20'h00000;
    localparam logic [NUM_UI-1:0] RST_UI_POL = 10'h000;
    localparam logic [NUM_CI-1:0] RST_CI_MODE = 4'h0;
    localparam logic [NUM_CI-1:0] RST_CI_POL = 4'h0;
    localparam logic [NUM_AO-1:0] RST_AO_BIN = 4'h0;
    localparam logic [AO_W-1:0] RST_AO_CODE = 8'h00;

    // universal input modes; the unused code behaves as analog
    typedef enum logic [1:0] {
        FIO_UI_ANALOG,
        FIO_UI_BINARY,
        FIO_UI_COUNTER
    } fio_ui_mode_e;

endpackage
